// ---- logic/hpoc_pattern.sv ----
// derives the order conversion setting from the host test pattern
`timescale 1ns/1ps
module hpoc_pattern (
   // raw pattern as fetched in board order
   input  wire logic [31:0]     pat_b,
   input  wire logic [15:0]     pat_w,
   input  wire logic [31:0]     pat_l,
   // result
   output hpoc_pkg::hpoc_conv_t conv,
   output logic                 ok
);

   logic ok_b;
   logic ok_w;
   logic ok_l;

   always_comb
   begin
      conv    = '0;
      ok_b    = 1'b1;
      ok_w    = 1'b1;
      ok_l    = 1'b1;
      if (pat_b == hpoc_pkg::PAT_BYTES_INV)
         conv.inv_a0 = 1'b1;
      else if (pat_b != hpoc_pkg::PAT_BYTES)
         ok_b = 1'b0;
      if (pat_w == hpoc_pkg::PAT_WORD_SWAP)
         conv.swap_w = 1'b1;
      else if (pat_w != hpoc_pkg::PAT_WORD)
         ok_w = 1'b0;
      unique case (pat_l)
         hpoc_pkg::PAT_LONG:      ok_l = 1'b1;
         hpoc_pkg::PAT_LONG_HALF: conv.swap_lh = 1'b1;
         hpoc_pkg::PAT_LONG_BYTE: conv.swap_lb = 1'b1;
         hpoc_pkg::PAT_LONG_BOTH:
         begin
            conv.swap_lh = 1'b1;
            conv.swap_lb = 1'b1;
         end
         default: ok_l = 1'b0;
      endcase
      ok = ok_b & ok_w & ok_l;
   end

endmodule : hpoc_pattern

// ---- logic/hpoc_pkg.sv ----
// shared types and constants for the host port and order conversion block
package hpoc_pkg;

   // -------------------------------------------------------------------
   // status byte layout
   // -------------------------------------------------------------------
   localparam int STS_ERR_FREE = 0;
   localparam int STS_IRQ      = 1;
   localparam int STS_READY    = 3;
   localparam logic [7:0] STS_IDLE = 8'h00;

   // -------------------------------------------------------------------
   // order test pattern as written in host-native order
   // -------------------------------------------------------------------
   localparam logic [31:0] PAT_BYTES      = 32'h0f07_0301;
   localparam logic [31:0] PAT_BYTES_INV  = 32'h070f_0103;
   localparam logic [15:0] PAT_WORD       = 16'h0103;
   localparam logic [15:0] PAT_WORD_SWAP  = 16'h0301;
   localparam logic [31:0] PAT_LONG       = 32'h0103_070f;
   localparam logic [31:0] PAT_LONG_HALF  = 32'h070f_0103;
   localparam logic [31:0] PAT_LONG_BYTE  = 32'h0301_0f07;
   localparam logic [31:0] PAT_LONG_BOTH  = 32'h0f07_0301;

   // -------------------------------------------------------------------
   // status indicator timing
   // -------------------------------------------------------------------
   localparam int CLK_KHZ     = 25000;
   localparam int LED_HALF_MS = 250;
   localparam int LED_HALF_CYC = LED_HALF_MS * CLK_KHZ;
   localparam logic [3:0] LED_CODE_NONE = 4'h0;
   localparam logic [3:0] LED_CODE_PAT  = 4'hf;

   // -------------------------------------------------------------------
   // enumerations
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {HPOC_IRQ_LINE, HPOC_IRQ_MEM, HPOC_IRQ_IO} hpoc_irq_t;
   typedef enum logic [1:0] {HPOC_MODE_LINK, HPOC_MODE_DLOAD, HPOC_MODE_NETBOOT} hpoc_mode_t;
   typedef enum logic [1:0] {HPOC_SZ_BYTE, HPOC_SZ_WORD, HPOC_SZ_LONG} hpoc_size_t;
   typedef enum logic [2:0] {
      HPOC_PH_DIAG, HPOC_PH_FATAL, HPOC_PH_WAIT_CFG, HPOC_PH_CFG_ERR, HPOC_PH_RUN
   } hpoc_phase_t;

   // -------------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------------
   typedef struct packed {
      logic inv_a0;
      logic swap_w;
      logic swap_lh;
      logic swap_lb;
   } hpoc_conv_t;

   typedef struct packed {
      logic        valid;
      logic        ok;
      hpoc_mode_t  mode;
      logic        conv_en;
      hpoc_irq_t   method;
      logic [3:0]  err_code;
      logic [23:0] irq_addr;
      logic [7:0]  irq_val;
      logic [31:0] pat_b;
      logic [15:0] pat_w;
      logic [31:0] pat_l;
   } hpoc_cfg_t;

   typedef struct packed {
      logic        valid;
      logic        is_io;
      logic        we;
      hpoc_size_t  size;
      logic [23:0] addr;
      logic [31:0] data;
   } hpoc_mreq_t;

endpackage : hpoc_pkg

// ---- logic/hpoc_swap.sv ----
// address and data order conversion for one host memory access
`timescale 1ns/1ps
module hpoc_swap (
   // conversion setting
   input  hpoc_pkg::hpoc_conv_t conv,
   input  wire logic            en,
   input  hpoc_pkg::hpoc_size_t size,
   // access in
   input  wire logic [23:0]     addr_in,
   input  wire logic [31:0]     data_in,
   // access out
   output logic [23:0]          addr_out,
   output logic [31:0]          data_out
);

   function automatic logic [15:0] swap16(input logic [15:0] v);
      swap16 = {v[7:0], v[15:8]};
   endfunction : swap16

   logic [31:0] d;

   always_comb
   begin
      d        = data_in;
      addr_out = addr_in;
      data_out = data_in;
      if (en)
      begin
         unique case (size)
            hpoc_pkg::HPOC_SZ_BYTE: addr_out[0] = addr_in[0] ^ conv.inv_a0;
            hpoc_pkg::HPOC_SZ_WORD:
               if (conv.swap_w)
                  data_out[15:0] = swap16(data_in[15:0]);
            hpoc_pkg::HPOC_SZ_LONG:
            begin
               if (conv.swap_lh)
                  d = {d[15:0], d[31:16]};
               if (conv.swap_lb)
                  d = {swap16(d[31:16]), swap16(d[15:0])};
               data_out = d;
            end
            default: data_out = data_in;
         endcase
      end
   end

endmodule : hpoc_swap

// ---- logic/hpoc_top.sv ----
// host port, host bus master and data order conversion of the front-end board
//
// What this block does
// - any host read of the reset port resets the board and restarts diagnostics
// - status bit 0 clears on reset, sets only after a passing self test
// - status bit 1 follows the level bus interrupt, line method only
// - any write to reset port drops the line interrupt and status bit 1, unless a new line request arrives in the same cycle
// - status bit 3 is high while the last mailbox byte is unread
// - write to status port hands a byte to the on-board CPU with interrupt
// - board masters the bus over 16 Mbyte memory, 64K I/O, interrupts host
// - host signalled by I/O write, memory write or line, chosen at configuration
// - no bus I/O cycles unless I/O-mapped host interrupts are selected
// - on-board memory is never visible to the host
// - with conversion enabled, pattern sets conversions for all later host accesses except the address of cpu I/O accesses
// - byte accesses invert host address bit 0 when needed
// - word accesses optionally swap their two bytes
// - longword accesses optionally swap halves, bytes in halves, or both
// - byte conversion covers message contents and every block transfer
// - failed diagnostics hold an error code until reset, else await configuration
// - failed configuration holds an error code until the next reset
// - valid configuration enters one of three operating modes
// - host presets completion code to FF, board overwrites it, zero success
`timescale 1ns/1ps
module hpoc_top #(
   parameter int LED_HALF_CYCLES = hpoc_pkg::LED_HALF_CYC
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   // host i/o slave
   input  wire logic             io_rd,
   input  wire logic             io_wr,
   input  wire logic [15:0]      io_addr,
   input  wire logic [7:0]       io_wdata,
   input  wire logic [15:0]      jmp_addr_a,
   input  wire logic [15:0]      jmp_addr_b,
   output logic [7:0]            io_rdata,
   output logic                  io_rdata_oe,
   // on-board cpu side
   input  wire logic             cpu_take,
   input  wire logic             cpu_diag_ok,
   input  wire logic             cpu_diag_fail,
   input  wire logic [3:0]       cpu_fail_code,
   input  hpoc_pkg::hpoc_cfg_t   cpu_cfg,
   input  wire logic             cpu_host_irq,
   input  hpoc_pkg::hpoc_mreq_t  cpu_mreq,
   output logic                  board_rst,
   output logic [7:0]            mbox_byte,
   output logic                  mbox_irq,
   output logic                  mst_done,
   output logic                  mst_err,
   output logic [31:0]           mst_rdata,
   output logic                  running,
   output hpoc_pkg::hpoc_mode_t  run_mode,
   // system bus master
   input  wire logic             bus_ack,
   input  wire logic [31:0]      bus_rdata,
   output logic [23:0]           bus_addr,
   output logic [31:0]           bus_wdata,
   output logic                  bus_mrd,
   output logic                  bus_mwr,
   output logic                  bus_iord,
   output logic                  bus_iowr,
   output logic                  bus_int,
   // status indicator
   output logic                  led,
   output logic [3:0]            led_code
);

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]           io_rdata;
      logic                 io_rdata_oe;
      logic                 board_rst;
      logic [7:0]           mbox_byte;
      logic                 mbox_irq;
      logic                 ready;
      logic                 err_free;
      logic                 irq_bit;
      logic                 bus_int;
      hpoc_pkg::hpoc_phase_t phase;
      hpoc_pkg::hpoc_mode_t run_mode;
      logic                 running;
      hpoc_pkg::hpoc_irq_t  method;
      logic                 conv_en;
      hpoc_pkg::hpoc_conv_t conv;
      logic [23:0]          irq_addr;
      logic [7:0]           irq_val;
      logic                 irq_pend;
      logic                 mst_busy;
      logic                 mst_own;
      hpoc_pkg::hpoc_size_t mst_size;
      logic [23:0]          bus_addr;
      logic [31:0]          bus_wdata;
      logic                 bus_mrd;
      logic                 bus_mwr;
      logic                 bus_iord;
      logic                 bus_iowr;
      logic [31:0]          mst_rdata;
      logic                 mst_done;
      logic                 mst_err;
      logic                 led;
      logic [3:0]           led_code;
      logic [23:0]          led_cnt;
   } hpoc_state_t;

   localparam hpoc_state_t ST_RESET = '{
      phase:    hpoc_pkg::HPOC_PH_DIAG,
      run_mode: hpoc_pkg::HPOC_MODE_LINK,
      method:   hpoc_pkg::HPOC_IRQ_LINE,
      mst_size: hpoc_pkg::HPOC_SZ_BYTE,
      led:      1'b1,
      led_code: hpoc_pkg::LED_CODE_NONE,
      default:  '0
   };

   localparam logic [23:0] LED_LAST = 24'(LED_HALF_CYCLES - 1);

   hpoc_state_t st_ff;
   hpoc_state_t nxt_st;

   // -------------------------------------------------------------------
   // conversion helpers
   // -------------------------------------------------------------------
   hpoc_pkg::hpoc_conv_t pat_conv;
   logic                 pat_ok;
   hpoc_pkg::hpoc_size_t req_size;
   logic [23:0]          req_addr;
   logic [31:0]          req_data;
   logic [23:0]          cnv_addr;
   logic [31:0]          cnv_wdata;
   logic [31:0]          cnv_rdata;

   hpoc_pattern u_pattern (
      .pat_b (cpu_cfg.pat_b),
      .pat_w (cpu_cfg.pat_w),
      .pat_l (cpu_cfg.pat_l),
      .conv  (pat_conv),
      .ok    (pat_ok)
   );

   // outbound: converts address and write data of every host access; cpu I/O accesses keep the unconverted address
   hpoc_swap u_swap_out (
      .conv     (st_ff.conv),
      .en       (st_ff.conv_en),
      .size     (req_size),
      .addr_in  (req_addr),
      .data_in  (req_data),
      .addr_out (cnv_addr),
      .data_out (cnv_wdata)
   );

   // inbound: same swap applied to read data, address ignored
   hpoc_swap u_swap_in (
      .conv     (st_ff.conv),
      .en       (st_ff.conv_en),
      .size     (st_ff.mst_size),
      .addr_in  (st_ff.bus_addr),
      .data_in  (bus_rdata),
      .addr_out (),
      .data_out (cnv_rdata)
   );

   // -------------------------------------------------------------------
   // port decode
   // -------------------------------------------------------------------
   logic hit_a;
   logic hit_b;
   logic irq_line_set;
   logic cpu_io_ok;
   logic irq_msg_set;

   // only the two jumpered ports answer, nothing else of the board is mapped
   assign hit_a        = (io_addr == jmp_addr_a);
   assign hit_b        = (io_addr == jmp_addr_b);
   assign irq_line_set = cpu_host_irq && (st_ff.method == hpoc_pkg::HPOC_IRQ_LINE) &&
                         (st_ff.phase == hpoc_pkg::HPOC_PH_RUN);
   assign cpu_io_ok    = (st_ff.method == hpoc_pkg::HPOC_IRQ_IO);
   assign irq_msg_set  = cpu_host_irq && (st_ff.method != hpoc_pkg::HPOC_IRQ_LINE) &&
                         (st_ff.phase == hpoc_pkg::HPOC_PH_RUN);

   // interrupt writes take the bus before cpu traffic
   always_comb
   begin
      if (st_ff.irq_pend)
      begin
         req_size = hpoc_pkg::HPOC_SZ_BYTE;
         req_addr = st_ff.irq_addr;
         req_data = {24'h00_0000, st_ff.irq_val};
      end
      else
      begin
         req_size = cpu_mreq.size;
         req_addr = cpu_mreq.addr;
         req_data = cpu_mreq.data;
      end
   end

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb
   begin
      nxt_st             = st_ff;
      nxt_st.io_rdata_oe = 1'b0;
      nxt_st.io_rdata    = hpoc_pkg::STS_IDLE;
      nxt_st.board_rst   = 1'b0;
      nxt_st.mst_done    = 1'b0;
      nxt_st.mst_err     = 1'b0;

      // host reads: status port returns the live status byte
      if (io_rd && hit_b)
      begin
         nxt_st.io_rdata_oe                    = 1'b1;
         nxt_st.io_rdata[hpoc_pkg::STS_ERR_FREE] = st_ff.err_free;
         nxt_st.io_rdata[hpoc_pkg::STS_IRQ]      = st_ff.irq_bit;
         nxt_st.io_rdata[hpoc_pkg::STS_READY]    = st_ff.ready;
      end
      else if (io_rd && hit_a)
         nxt_st.io_rdata_oe = 1'b1;

      // mailbox: ready bit set wins over the cpu taking the byte
      if (cpu_take)
      begin
         nxt_st.ready    = 1'b0;
         nxt_st.mbox_irq = 1'b0;
      end
      if (io_wr && hit_b)
      begin
         nxt_st.mbox_byte = io_wdata;
         nxt_st.mbox_irq  = 1'b1;
         nxt_st.ready     = 1'b1;
      end

      // line interrupt: a new request in the ack cycle stays asserted
      if (io_wr && hit_a)
      begin
         nxt_st.bus_int = 1'b0;
         nxt_st.irq_bit = 1'b0;
      end
      if (irq_line_set)
      begin
         nxt_st.bus_int = 1'b1;
         nxt_st.irq_bit = 1'b1;
      end
      if (irq_msg_set)
         nxt_st.irq_pend = 1'b1;

      // initialization phases
      unique case (st_ff.phase)
         hpoc_pkg::HPOC_PH_DIAG:
         begin
            nxt_st.led = 1'b1;
            if (cpu_diag_fail)
            begin
               nxt_st.phase    = hpoc_pkg::HPOC_PH_FATAL;
               nxt_st.led_code = cpu_fail_code;
            end
            else if (cpu_diag_ok)
            begin
               nxt_st.phase    = hpoc_pkg::HPOC_PH_WAIT_CFG;
               nxt_st.err_free = 1'b1;
            end
         end
         hpoc_pkg::HPOC_PH_WAIT_CFG:
            if (cpu_cfg.valid)
            begin
               if (!cpu_cfg.ok)
               begin
                  nxt_st.phase    = hpoc_pkg::HPOC_PH_CFG_ERR;
                  nxt_st.led_code = cpu_cfg.err_code;
               end
               else if (cpu_cfg.conv_en && !pat_ok)
               begin
                  nxt_st.phase    = hpoc_pkg::HPOC_PH_CFG_ERR;
                  nxt_st.led_code = hpoc_pkg::LED_CODE_PAT;
               end
               else
               begin
                  nxt_st.phase    = hpoc_pkg::HPOC_PH_RUN;
                  nxt_st.run_mode = cpu_cfg.mode;
                  nxt_st.method   = cpu_cfg.method;
                  nxt_st.irq_addr = cpu_cfg.irq_addr;
                  nxt_st.irq_val  = cpu_cfg.irq_val;
                  nxt_st.conv_en  = cpu_cfg.conv_en;
                  nxt_st.conv     = cpu_cfg.conv_en ? pat_conv : '0;
               end
            end
         // error phases and the run phase are left only through a board reset
         hpoc_pkg::HPOC_PH_FATAL,
         hpoc_pkg::HPOC_PH_CFG_ERR,
         hpoc_pkg::HPOC_PH_RUN: nxt_st.phase = st_ff.phase;
         default: nxt_st.phase = hpoc_pkg::HPOC_PH_DIAG;
      endcase

      // indicator: steady during diagnostics, blinking otherwise
      if (st_ff.phase != hpoc_pkg::HPOC_PH_DIAG)
      begin
         if (st_ff.led_cnt >= LED_LAST)
         begin
            nxt_st.led_cnt = '0;
            nxt_st.led     = ~st_ff.led;
         end
         else
            nxt_st.led_cnt = st_ff.led_cnt + 24'h00_0001;
      end

      // bus master: one access at a time, no timeout on a missing ack
      if (!st_ff.mst_busy)
      begin
         if (st_ff.irq_pend)
         begin
            // a request in the launch cycle stays pending, set wins
            nxt_st.irq_pend  = irq_msg_set;
            nxt_st.mst_busy  = 1'b1;
            nxt_st.mst_own   = 1'b1;
            nxt_st.mst_size  = req_size;
            nxt_st.bus_addr  = cnv_addr;
            nxt_st.bus_wdata = cnv_wdata;
            nxt_st.bus_mwr   = (st_ff.method == hpoc_pkg::HPOC_IRQ_MEM);
            nxt_st.bus_iowr  = (st_ff.method == hpoc_pkg::HPOC_IRQ_IO);
         end
         else if (cpu_mreq.valid && cpu_mreq.is_io && !cpu_io_ok)
            nxt_st.mst_err = 1'b1;
         else if (cpu_mreq.valid)
         begin
            nxt_st.mst_busy  = 1'b1;
            nxt_st.mst_own   = 1'b0;
            nxt_st.mst_size  = req_size;
            nxt_st.bus_wdata = cnv_wdata;
            if (cpu_mreq.is_io)
            begin
               nxt_st.bus_addr = {8'h00, req_addr[15:0]};
               nxt_st.bus_iord = !cpu_mreq.we;
               nxt_st.bus_iowr = cpu_mreq.we;
            end
            else
            begin
               nxt_st.bus_addr = cnv_addr;
               nxt_st.bus_mrd  = !cpu_mreq.we;
               nxt_st.bus_mwr  = cpu_mreq.we;
            end
         end
      end
      else if (bus_ack)
      begin
         nxt_st.mst_busy = 1'b0;
         nxt_st.bus_mrd  = 1'b0;
         nxt_st.bus_mwr  = 1'b0;
         nxt_st.bus_iord = 1'b0;
         nxt_st.bus_iowr = 1'b0;
         if (!st_ff.mst_own)
         begin
            nxt_st.mst_done  = 1'b1;
            nxt_st.mst_rdata = cnv_rdata;
         end
      end

      // a read of the reset port overrides everything else
      if (io_rd && hit_a)
      begin
         nxt_st             = ST_RESET;
         nxt_st.board_rst   = 1'b1;
         nxt_st.io_rdata_oe = 1'b1;
      end
      // own flop so the pin carries no decode
      nxt_st.running = (nxt_st.phase == hpoc_pkg::HPOC_PH_RUN);
   end

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         st_ff <= ST_RESET;
      else
         st_ff <= nxt_st;
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign io_rdata    = st_ff.io_rdata;
   assign io_rdata_oe = st_ff.io_rdata_oe;
   assign board_rst   = st_ff.board_rst;
   assign mbox_byte   = st_ff.mbox_byte;
   assign mbox_irq    = st_ff.mbox_irq;
   assign mst_done    = st_ff.mst_done;
   assign mst_err     = st_ff.mst_err;
   assign mst_rdata   = st_ff.mst_rdata;
   assign running     = st_ff.running;
   assign run_mode    = st_ff.run_mode;
   assign bus_addr    = st_ff.bus_addr;
   assign bus_wdata   = st_ff.bus_wdata;
   assign bus_mrd     = st_ff.bus_mrd;
   assign bus_mwr     = st_ff.bus_mwr;
   assign bus_iord    = st_ff.bus_iord;
   assign bus_iowr    = st_ff.bus_iowr;
   assign bus_int     = st_ff.bus_int;
   assign led         = st_ff.led;
   assign led_code    = st_ff.led_code;

endmodule : hpoc_top

// ---- verification/hpoc_bus_mem.sv ----
// host memory model answering the board bus master
`timescale 1ns/1ps
module hpoc_bus_mem (
   // bus master side
   input  wire logic [23:0] bus_addr,
   input  wire logic [31:0] bus_wdata,
   input  wire logic        sys_clk, bus_mrd, bus_mwr,
   output logic             bus_ack = '0,
   output logic [31:0]      bus_rdata = '0
);
   logic [31:0] mem [16];
   int cnt = 0, lim = 0;
   initial foreach (mem[i]) mem[i] = (i == 0) ? 32'h0000_00ff : hpoc_pkg::PAT_LONG;
   // waits alternate 0 and 2 cycles; released data toggles
   always @(posedge sys_clk)
   begin
      bus_ack <= '0;
      bus_rdata <= ~bus_rdata;
      cnt <= (bus_mrd || bus_mwr) && !bus_ack ? cnt + 1 : 0;
      if ((bus_mrd || bus_mwr) && !bus_ack && cnt >= lim)
      begin
         bus_ack <= 1'b1;
         lim <= 2 - lim;
         bus_rdata <= mem[bus_addr[5:2]];
         if (bus_mwr) mem[bus_addr[5:2]] <= bus_wdata;
      end
   end
endmodule : hpoc_bus_mem

// ---- verification/hpoc_top_properties.sv ----
// assertions on the host port block pins
`timescale 1ns/1ps
module hpoc_top_properties (
   // host port and board side
   input wire logic        sys_clk, resetn, io_rd, io_wr, io_rdata_oe, cpu_take, cpu_host_irq,
   input wire logic        board_rst, mbox_irq, mst_done, bus_ack, bus_mrd, bus_int,
   input wire logic [15:0] io_addr, jmp_addr_a, jmp_addr_b,
   input wire logic [7:0]  io_wdata, io_rdata, mbox_byte,
   input wire logic [23:0] bus_addr
);
   wire logic ha = io_addr == jmp_addr_a;
   wire logic hb = io_addr == jmp_addr_b;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   AST_RD_A: assert property (io_rd && ha |=> board_rst && io_rdata_oe && io_rdata == 8'h00) else $error("rd a");
   AST_RD_B: assert property (io_rd && hb |=> io_rdata_oe && io_rdata[7:4] == 4'h0) else $error("rd b");
   AST_NODEC: assert property (!(io_rd && (ha || hb)) |=> !io_rdata_oe) else $error("decode");
   AST_MBOX: assert property (io_wr && hb |=> mbox_irq && mbox_byte == $past(io_wdata)) else $error("mbox");
   AST_ACK_A: assert property (io_wr && ha && !cpu_host_irq |=> !bus_int) else $error("int ack");
   AST_TAKE: assert property (cpu_take && !(io_wr && hb) |=> !mbox_irq) else $error("take");
   AST_HOLD: assert property (bus_mrd && !bus_ack |=> bus_mrd && $stable(bus_addr)) else $error("hold");
   AST_DONE: assert property (bus_ack && bus_mrd |=> mst_done ##1 !mst_done) else $error("done");
endmodule : hpoc_top_properties
bind hpoc_top hpoc_top_properties hpoc_top_properties_inst (.*);

// ---- verification/tb_host_port_and_order_conversion.sv ----
// self-checking bench for the host port block
`timescale 1ns/1ps
module tb_host_port_and_order_conversion;
   localparam logic [15:0] PA = 16'h0310;
   localparam logic [15:0] PB = 16'h0314;
   logic sys_clk = '0, resetn = '0, io_rd = '0, io_wr = '0, cpu_take = '0, cpu_diag_ok = '0, cpu_host_irq = '0;
   logic bus_ack, bus_mrd, bus_mwr, io_rdata_oe, board_rst, mbox_irq, mst_done, mst_err, running, bus_int;
   logic [15:0] io_addr = '0;
   logic [7:0] io_wdata = '0, io_rdata, mbox_byte;
   logic [23:0] bus_addr;
   logic [31:0] bus_rdata, bus_wdata, mst_rdata;
   logic [3:0] led_code;
   logic bus_iord, bus_iowr, led;
   logic [31:0] pl [4] = '{hpoc_pkg::PAT_LONG, hpoc_pkg::PAT_LONG_BOTH, hpoc_pkg::PAT_LONG_HALF, '0};
   logic [31:0] ex [3] = '{hpoc_pkg::PAT_LONG, 32'h0f07_0301, 32'h070f_0103};
   logic [7:0] mb [8] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h34, 8'h12, 8'h00, 8'h00};
   hpoc_pkg::hpoc_cfg_t cpu_cfg = '0;
   hpoc_pkg::hpoc_mreq_t cpu_mreq = '0;
   hpoc_pkg::hpoc_mode_t run_mode;
   int err_total = 0, comparisons = 0, cyc = 0;
   hpoc_top #(.LED_HALF_CYCLES(4)) hpoc_top_inst (.*, .jmp_addr_a(PA), .jmp_addr_b(PB), .cpu_diag_fail('0),
      .cpu_fail_code('0));
   hpoc_bus_mem hpoc_bus_mem_inst (.*);
   task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task io(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk) {io_rd, io_wr, io_addr, io_wdata} <= {!w, w, a, d};
      @(posedge sys_clk) {io_rd, io_wr} <= 2'b00;
      #1;
   endtask : io
   // no timeout in the board, so a missing ack is caught here
   task mreq(input logic isio, input logic [31:0] exp);
      int n;
      n = 0;
      @(posedge sys_clk) cpu_mreq <= '{1'b1, isio, 1'b0, hpoc_pkg::HPOC_SZ_LONG, 24'h00_0010, 32'h0000_0000};
      @(posedge sys_clk);
      while (!isio && !bus_ack && n++ < 50) @(posedge sys_clk);
      cpu_mreq.valid <= '0;
      #1 chk("master", isio ? mst_err : mst_done, 1'b1);
      if (!isio) chk("mst_rdata", mst_rdata, exp);
   endtask : mreq
   task test_done;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   initial forever #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_total++;
         test_done();
      end
   end
   initial
   begin
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int p = 0; p < 4; p++)
      begin
         io(1'b0, PA, '0);
         chk("board_rst", board_rst, 1'b1);
         chk("led", led, 1'b1);
         io(1'b0, PB, '0);
         chk("status", io_rdata, 8'h00);
         @(posedge sys_clk) cpu_diag_ok <= 1'b1;
         @(posedge sys_clk) cpu_diag_ok <= '0;
         io(1'b0, PB, '0);
         chk("status", io_rdata, 8'h01);
         @(posedge sys_clk) cpu_cfg <= '{1'b1, 1'b1, hpoc_pkg::hpoc_mode_t'(p), 1'b1,
            hpoc_pkg::hpoc_irq_t'(p == 1 ? hpoc_pkg::HPOC_IRQ_MEM : hpoc_pkg::HPOC_IRQ_LINE), 4'h0, 24'h00_0020,
            8'h3c, hpoc_pkg::PAT_BYTES, hpoc_pkg::PAT_WORD, pl[p]};
         @(posedge sys_clk) cpu_cfg.valid <= '0;
         #1 chk("running", running, p < 3);
         if (p == 3) chk("led_code", led_code, hpoc_pkg::LED_CODE_PAT);
         else
         begin
            chk("run_mode", run_mode, p);
            mreq(1'b0, ex[p]);
            mreq(1'b1, '0);
            chk("no_io", {bus_iord, bus_iowr}, 2'b00);
            // location handover: prefix then address, one byte per free mailbox
            for (int b = 0; b < 8; b++)
            begin
               io(1'b0, PB, '0);
               chk("ready", io_rdata[3], 1'b0);
               io(1'b1, PB, mb[b]);
               chk("mbox_byte", mbox_byte, mb[b]);
               io(1'b0, PB, '0);
               chk("status", io_rdata, 8'h09);
               @(posedge sys_clk) {cpu_take, cpu_host_irq} <= {1'b1, b == 7};
               @(posedge sys_clk) {cpu_take, cpu_host_irq} <= 2'b00;
            end
            io(1'b0, PB, '0);
            chk("status", io_rdata, p == 1 ? 8'h01 : 8'h03);
            io(1'b1, PA, 8'h5a);
            chk("bus_int", bus_int, 1'b0);
            if (p == 1) chk("irq_write", hpoc_bus_mem_inst.mem[8], 32'h0000_003c);
            io(1'b0, PB, '0);
            chk("status", io_rdata, 8'h01);
         end
         $display("pass %0d done", p);
      end
      test_done();
   end
endmodule : tb_host_port_and_order_conversion
